/* bench/haptic_sequence_trigger_control_tb.sv */
/*
 * Self-checking bench for the playback control block.
 * It assumes the package, the block and wave_engine_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module haptic_sequence_trigger_control_tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic        hwrite = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        trig0 = 1'h0;
	logic        trig1 = 1'h0;
	logic        trig2 = 1'h0;
	logic [14:0] per;
	logic [31:0] hrdata, q;
	logic        hrdy, hresp, pdone, pstart, drv, stby, gain, od, brk, irq_n;
	logic [3:0]  pseq, sel, rc;
	logic [14:0] dper;
	int          errors = 0, checks_done = 0, starts = 0, evts = 0;
	always #50 hclk = ~hclk;
	// Count pass starts, so that repeats can be checked
	always @(posedge hclk) if (pstart === 1'h1) starts++;
	haptic_sequence_trigger_control #(.BOOT_CYCLES(20)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.trigger_input_0(trig0), .trigger_input_1(trig1), .trigger_input_2(trig2),
		.pass_done(pdone), .play_start(pstart), .play_seq(pseq), .drive_active(drv),
		.standby_active(stby), .bemf('0), .drive_period(dper), .gain_autoscale_on(gain),
		.overdrive_on(od), .brake_on(brk), .interrupt_out_n(irq_n));
	wave_engine_model engine (.hclk(hclk), .hresetn(hresetn), .play_start(pstart),
		.drive_active(drv), .pass_done(pdone));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bounded wait for a level; running out ends the run
	task automatic wait_for(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 3000) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 3000) begin
			errors++;
			finish_test();
		end
	endtask
	// One single AHB-Lite transfer; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		wait_for(hrdy, 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		wait_for(hrdy, 1'h1);
		q = hrdata;
	endtask
	task automatic run_out();
		repeat (3) @(negedge hclk);
		wait_for(drv, 1'h0);
		repeat (2) @(negedge hclk);
	endtask
	function automatic logic qual(input logic [1:0] es, input logic rise);
		return es == 2'h2 || es == {1'h0, !rise};
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(57));
		repeat (10) @(posedge hclk);
		chk("irq_reset", irq_n, 1'h1);
		hresetn <= 1'h1;
		bus(1'h0, 8'h10, 32'h0);
		chk("boot_state", q[3:2], 2'h0);
		repeat (25) @(posedge hclk);
		bus(1'h0, 8'h10, 32'h0);
		chk("idle_state", q[3:2], 2'h1);
		// Register trigger: mask and standby vary, pins must do nothing
		for (int k = 0; k < 4; k++) begin
			sel = 4'($urandom);
			rc = 4'($urandom % 3);
			bus(1'h1, 8'h00, {20'h0, k[0], 7'h0, k[1], 3'h3});
			trig1 <= ~trig1;
			trig2 <= ~trig2;
			repeat (8) @(negedge hclk);
			chk("pin_ignored", drv, 1'h0);
			starts = 0;
			bus(1'h1, 8'h04, {23'h0, 1'h1, rc, sel});
			repeat (2) @(negedge hclk);
			chk("seq", {drv, pseq}, {1'h1, sel});
			run_out();
			chk("passes", starts, rc + 1);
			chk("irq", irq_n, k[0]);
			bus(1'h0, 8'h10, 32'h0);
			chk("end_state", q[3:0], {k[1] ? 2'h2 : 2'h1, 2'h1});
			bus(1'h1, 8'h10, 32'h1);
		end
		// Repeat request keeps restarting until it is cleared
		bus(1'h1, 8'h00, 32'h13);
		starts = 0;
		bus(1'h1, 8'h04, 32'h100);
		repeat (100) @(negedge hclk);
		chk("repeat_run", {drv, starts > 1}, 2'h3);
		bus(1'h1, 8'h00, 32'h3);
		run_out();
		bus(1'h1, 8'h10, 32'h1);
		$display("register trigger test done");
		// Pin trigger: every edge select, both sequence schemes
		bus(1'h1, 8'h04, 32'h0);
		bus(1'h1, 8'h00, 32'h4);
		for (int k = 0; k < 6; k++) begin
			sel = 4'($urandom % 15);
			bus(1'h1, 8'h08, {25'h0, sel, k[0], 2'(k / 2)});
			@(posedge hclk);
			trig0 <= ~trig0;
			repeat (8) @(negedge hclk);
			if (qual(2'(k / 2), trig0))
				evts++;
			chk("pin_start", drv, qual(2'(k / 2), trig0));
			if (drv === 1'h1)
				chk("pin_seq", pseq, (k[0] && !evts[0]) ? sel + 4'h1 : sel);
			run_out();
			chk("pin_irq", irq_n, !qual(2'(k / 2), trig0));
			bus(1'h1, 8'h10, 32'h1);
		end
		// A second event while a pin-started sequence plays stops it
		for (int k = 0; k < 2; k++) begin
			@(posedge hclk);
			trig0 <= ~trig0;
			repeat (8) @(negedge hclk);
		end
		chk("stopped", drv, 1'h0);
		bus(1'h0, 8'h10, 32'h0);
		chk("no_done", q[0], 1'h0);
		$display("pin trigger test done");
		// Enables, wideband override and period follow
		for (int k = 0; k < 8; k++) begin
			per = 15'(2500 + $urandom % 12500);
			bus(1'h1, 8'h00, {21'h0, k[2:0], 2'h0, !k[2], 5'h03});
			bus(1'h1, 8'h0C, {17'h0, per});
			// The period in use follows the nominal one a cycle after the write
			repeat (2) @(negedge hclk);
			chk("overdrive", od, k[0] && !k[2]);
			chk("brake", brk, k[1] && !k[2]);
			if (k[2])
				chk("period", dper, per);
		end
		$display("enable test done");
		finish_test();
	end
endmodule
`default_nettype wire

/* bench/wave_engine_model.sv */
/*
 * Stand-in for the waveform engine: it ends each pass a random 30 to 45
 * cycles after play_start. It assumes it shares hclk and hresetn with the block.
 */
`timescale 1ns/1ps
`default_nettype none
module wave_engine_model (
	// Clock, reset and block side
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic play_start,
	input  wire logic drive_active,
	output logic      pass_done
);
	int left;  // Cycles left in the pass, 0 when no pass runs
	// A stopped sequence drops drive_active, so an aborted pass never reports
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left <= 0;
			pass_done <= 1'h0;
		end else begin
			pass_done <= (left == 1) && drive_active;
			if (play_start)
				left <= 30 + $urandom % 16;
			else if (left > 0)
				left <= left - 1;
		end
	end
endmodule
`default_nettype wire

/* design/haptic_sequence_trigger_control.sv */
/*
 * Playback control for a haptic driver: register and pin triggered
 * sequence start, repeat, stop-on-retrigger, alternation, completion
 * interrupt, resonance tracking checks and boot timing.
 * Assumes a waveform engine on hclk that plays the sequence named by
 * play_seq on each play_start pulse and pulses pass_done when a pass ends,
 * and a sensing front end that reports the measured period on hclk.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Mode 3 plays only on register trigger
// - Play selected sequence, up to 16 passes
// - Writing trigger bit starts selected sequence
// - Completion pulls interrupt low, records done
// - Repeat request restarts sequence without gap
// - Edge mode starts on pins or register
// - Per input: rising, falling or both edges
// - New event during pin playback stops it
// - Scheme 0 always plays configured slot
// - Scheme 1 alternates slot and slot plus one
// - Pin playback ends, interrupt, then idle or standby
// - Tracking adjusts period within 50-300 Hz
// - Gain autoscale only after initial lock
// - Tracking converges within 25 percent of nominal
// - Fault when resonance outside 50-300 Hz
// - Bypass disables window and range fault
// - Overdrive and braking have separate enables
// - Wideband: 25-1000 Hz, tracking features off
// - Wideband period follows period register writes
// - Boot 1.5 ms, then inactive lowest power
// - Mode 4 selects edge-triggered playback
// - After playback go idle or standby
module haptic_sequence_trigger_control #(
	parameter int BOOT_CYCLES = haptic_trig_pkg::BOOT_CYCLES
) (
	// Clock and reset
	input  wire  logic        hclk,
	input  wire  logic        hresetn,
	// AHB-Lite slave
	input  wire  logic        hsel,
	input  wire  logic [1:0]  htrans,
	input  wire  logic [31:0] haddr,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic [31:0] hwdata,
	input  wire  logic        hready,
	output logic [31:0]       hrdata,
	output logic              hreadyout,
	output logic              hresp,
	// Trigger pins, asynchronous
	input  wire  logic        trigger_input_0,
	input  wire  logic        trigger_input_1,
	input  wire  logic        trigger_input_2,
	// Waveform engine
	input  wire  logic        pass_done,
	output logic              play_start,
	output logic [3:0]        play_seq,
	output logic              drive_active,
	output logic              standby_active,
	// Resonance sensing
	input  wire  haptic_trig_pkg::bemf_t bemf,
	output logic [14:0]       drive_period,
	output logic              gain_autoscale_on,
	output logic              overdrive_on,
	output logic              brake_on,
	// Interrupt
	output logic              interrupt_out_n
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		haptic_trig_pkg::pstate_t state;        // Power/playback state
		logic [haptic_trig_pkg::BOOT_W-1:0] boot_cnt;
		logic [2:0]  mode;                      // Playback mode field
		logic        standby_en;                // Post-playback standby
		logic        repeat_req;                // sequence_repeat_request
		logic        trk_en;                    // Resonance tracking
		logic        autoscale;                 // tracking_gain_autoscale
		logic        bypass;                    // Tracking limits bypass
		logic        od_en;                     // Overdrive enable
		logic        brake_en;                  // Reverse braking enable
		logic        wide_en;                   // Wideband operation
		logic        done_mask;                 // sequence_done_mask
		logic [3:0]  sel;                       // sequence_select
		logic [3:0]  rpt;                       // sequence_repeat_count
		logic [23:0] trig;                      // Three trig_cfg_t
		logic [14:0] nominal;                   // drive_period_high/low
		logic        done;                      // Sticky sequence done
		logic        fault;                     // Sticky frequency fault
		logic        by_pin;                    // Playback started by pin
		logic [3:0]  seq;                       // Sequence now playing
		logic [3:0]  pass_cnt;                  // Passes completed
		logic [2:0]  toggle;                    // Odd/even event per input
		logic [2:0]  sync0;                     // First sync stage
		logic [2:0]  sync1;                     // Second sync stage
		logic [2:0]  sync2;                     // Edge history
		logic        locked;                    // Initial lock reached
		logic [14:0] period;                    // Drive period in use
		logic        play_start;                // Pass start pulse
		logic        irq_n;                     // Interrupt pin
		logic        wr_pend;                   // Write data phase due
		logic [2:0]  wr_sel;                    // Register of that write
		logic [31:0] rdata;                     // Read data
	} regs_t;

	regs_t r_ff;
	regs_t nxt_r;

	// Register decode, used for reads and writes
	function automatic logic [2:0] reg_sel(input logic [31:0] a);
		logic [2:0] s;
		s = haptic_trig_pkg::SEL_NONE;
		if (a[31:8] == 24'h000000) begin
			case (a[7:0])
				haptic_trig_pkg::OFS_CTRL:   s = haptic_trig_pkg::SEL_CTRL;
				haptic_trig_pkg::OFS_SEQ:    s = haptic_trig_pkg::SEL_SEQ;
				haptic_trig_pkg::OFS_TRIG:   s = haptic_trig_pkg::SEL_TRIG;
				haptic_trig_pkg::OFS_PERIOD: s = haptic_trig_pkg::SEL_PERIOD;
				haptic_trig_pkg::OFS_STATUS: s = haptic_trig_pkg::SEL_STATUS;
				default:                     s = haptic_trig_pkg::SEL_NONE;
			endcase
		end
		return s;
	endfunction

	// Combinational helpers
	logic [2:0]  ev;          // Qualifying event per input
	logic        any_ev;
	logic        reg_trig;    // Host wrote the trigger bit
	logic        can_start;
	logic        pass_end;
	logic        seq_end;
	logic [16:0] win_lo;
	logic [16:0] win_hi;
	logic        in_win;
	logic        in_range;
	haptic_trig_pkg::trig_cfg_t cfg [3];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_r = r_ff;
		nxt_r.play_start = 1'b0;
		// Two flops on each pin before any logic looks at them
		nxt_r.sync0 = {trigger_input_2, trigger_input_1, trigger_input_0};
		nxt_r.sync1 = r_ff.sync0;
		nxt_r.sync2 = r_ff.sync1;

		// Edge qualification per input
		ev = 3'b000;
		for (int i = 0; i < 3; i++) begin
			cfg[i] = r_ff.trig[i*haptic_trig_pkg::TRIG_STRIDE +: 7];
			case (cfg[i].edge_sel)
				haptic_trig_pkg::EDGE_RISE: ev[i] = r_ff.sync1[i] & ~r_ff.sync2[i];
				haptic_trig_pkg::EDGE_FALL: ev[i] = ~r_ff.sync1[i] & r_ff.sync2[i];
				haptic_trig_pkg::EDGE_BOTH: ev[i] = r_ff.sync1[i] ^ r_ff.sync2[i];
				default:                    ev[i] = 1'b0;
			endcase
		end
		// Pins count only in edge mode
		if (r_ff.mode != haptic_trig_pkg::MODE_EDGE_TRIG) begin
			ev = 3'b000;
		end
		any_ev = |ev;

		// AHB write data phase
		reg_trig = 1'b0;
		if (r_ff.wr_pend) begin
			case (r_ff.wr_sel)
				haptic_trig_pkg::SEL_CTRL: begin
					nxt_r.mode       = hwdata[haptic_trig_pkg::CTRL_MODE_LSB +: 3];
					nxt_r.standby_en = hwdata[haptic_trig_pkg::CTRL_STBY];
					nxt_r.repeat_req = hwdata[haptic_trig_pkg::CTRL_RPTREQ];
					nxt_r.trk_en     = hwdata[haptic_trig_pkg::CTRL_TRK];
					nxt_r.autoscale  = hwdata[haptic_trig_pkg::CTRL_AUTO];
					nxt_r.bypass     = hwdata[haptic_trig_pkg::CTRL_BYPASS];
					nxt_r.od_en      = hwdata[haptic_trig_pkg::CTRL_OD];
					nxt_r.brake_en   = hwdata[haptic_trig_pkg::CTRL_BRAKE];
					nxt_r.wide_en    = hwdata[haptic_trig_pkg::CTRL_WIDE];
					nxt_r.done_mask  = hwdata[haptic_trig_pkg::CTRL_DMASK];
				end
				haptic_trig_pkg::SEL_SEQ: begin
					nxt_r.sel = hwdata[haptic_trig_pkg::SEQ_SEL_LSB +: 4];
					nxt_r.rpt = hwdata[haptic_trig_pkg::SEQ_RPT_LSB +: 4];
					reg_trig  = hwdata[haptic_trig_pkg::SEQ_TRIG];
				end
				haptic_trig_pkg::SEL_TRIG:   nxt_r.trig = hwdata[23:0];
				haptic_trig_pkg::SEL_PERIOD: nxt_r.nominal = hwdata[14:0];
				haptic_trig_pkg::SEL_STATUS: begin
					// Write one clears; a same-cycle set below still wins
					if (hwdata[haptic_trig_pkg::ST_DONE]) nxt_r.done = 1'b0;
					if (hwdata[haptic_trig_pkg::ST_FAULT]) nxt_r.fault = 1'b0;
				end
				default: ;
			endcase
		end
		// Register trigger counts in both stored-playback modes
		if ((r_ff.mode != haptic_trig_pkg::MODE_REG_TRIG) &&
		    (r_ff.mode != haptic_trig_pkg::MODE_EDGE_TRIG)) begin
			reg_trig = 1'b0;
		end
		can_start = (r_ff.state == haptic_trig_pkg::ST_IDLE ||
		             r_ff.state == haptic_trig_pkg::ST_STANDBY) && !r_ff.fault;

		// Resonance window and range checks
		win_lo   = {2'b00, r_ff.nominal} - {4'h0, r_ff.nominal[14:2]};
		win_hi   = {2'b00, r_ff.nominal} + {4'h0, r_ff.nominal[14:2]};
		in_win   = ({2'b00, bemf.period} >= win_lo) && ({2'b00, bemf.period} <= win_hi);
		in_range = (bemf.period >= haptic_trig_pkg::PER_MIN) &&
		           (bemf.period <= haptic_trig_pkg::PER_MAX);

		pass_end = (r_ff.state == haptic_trig_pkg::ST_DRIVE) && pass_done;
		seq_end  = pass_end && (r_ff.pass_cnt == r_ff.rpt);

		// Playback sequencing
		case (r_ff.state)
			haptic_trig_pkg::ST_BOOT: begin
				// Wait out boot, then sit in the lowest power state
				if (r_ff.boot_cnt == haptic_trig_pkg::BOOT_W'(BOOT_CYCLES - 1)) begin
					nxt_r.state = haptic_trig_pkg::ST_IDLE;
				end else begin
					nxt_r.boot_cnt = r_ff.boot_cnt + 1'b1;
				end
			end
			haptic_trig_pkg::ST_IDLE, haptic_trig_pkg::ST_STANDBY: begin
				if (can_start && any_ev) begin
					// Lowest numbered input wins a tie
					for (int i = 2; i >= 0; i--) begin
						if (ev[i]) begin
							nxt_r.seq = cfg[i].slot;
							if (cfg[i].scheme && r_ff.toggle[i]) begin
								nxt_r.seq = cfg[i].slot + 4'h1;
							end
						end
					end
					nxt_r.by_pin     = 1'b1;
					nxt_r.state      = haptic_trig_pkg::ST_DRIVE;
					nxt_r.pass_cnt   = 4'h0;
					nxt_r.play_start = 1'b1;
					nxt_r.locked     = 1'b0;
				end else if (can_start && reg_trig) begin
					// The trigger write may carry a new selection in the same word
					nxt_r.seq        = nxt_r.sel;
					nxt_r.by_pin     = 1'b0;
					nxt_r.state      = haptic_trig_pkg::ST_DRIVE;
					nxt_r.pass_cnt   = 4'h0;
					nxt_r.play_start = 1'b1;
					nxt_r.locked     = 1'b0;
				end
			end
			haptic_trig_pkg::ST_DRIVE: begin
				if (r_ff.by_pin && any_ev) begin
					// Retrigger during pin playback only stops it
					nxt_r.state = r_ff.standby_en ? haptic_trig_pkg::ST_STANDBY :
					              haptic_trig_pkg::ST_IDLE;
				end else if (seq_end) begin
					nxt_r.done = 1'b1;
					if (r_ff.repeat_req) begin
						nxt_r.pass_cnt   = 4'h0;
						nxt_r.play_start = 1'b1;
					end else begin
						nxt_r.state = r_ff.standby_en ? haptic_trig_pkg::ST_STANDBY :
						              haptic_trig_pkg::ST_IDLE;
					end
				end else if (pass_end) begin
					nxt_r.pass_cnt   = r_ff.pass_cnt + 4'h1;
					nxt_r.play_start = 1'b1;
				end
			end
			default: nxt_r.state = haptic_trig_pkg::ST_IDLE;
		endcase

		// Every event on an input outside boot flips its odd/even toggle
		for (int i = 0; i < 3; i++) begin
			if (ev[i] && r_ff.state != haptic_trig_pkg::ST_BOOT) begin
				nxt_r.toggle[i] = ~r_ff.toggle[i];
			end
		end

		// Resonance tracking and wideband period
		if (r_ff.wide_en || !r_ff.trk_en) begin
			nxt_r.period = r_ff.nominal;
			nxt_r.locked = 1'b0;
		end else if (r_ff.state == haptic_trig_pkg::ST_DRIVE && bemf.valid) begin
			if (!r_ff.bypass && !in_range) begin
				nxt_r.fault = 1'b1;
				nxt_r.state = haptic_trig_pkg::ST_IDLE;
			end else if (r_ff.bypass || in_win) begin
				nxt_r.period = bemf.period;
				nxt_r.locked = 1'b1;
			end
		end else if (r_ff.state != haptic_trig_pkg::ST_DRIVE) begin
			nxt_r.period = r_ff.nominal;
		end

		// Interrupt follows the unmasked done flag
		nxt_r.irq_n = ~(nxt_r.done & ~nxt_r.done_mask);

		// AHB address phase
		nxt_r.wr_pend = 1'b0;
		if (hsel && htrans[1] && hready) begin
			nxt_r.wr_pend = hwrite;
			nxt_r.wr_sel  = reg_sel(haddr);
			nxt_r.rdata   = 32'h00000000;
			if (!hwrite) begin
				case (reg_sel(haddr))
					haptic_trig_pkg::SEL_CTRL: nxt_r.rdata = {20'h00000, r_ff.done_mask,
						r_ff.wide_en, r_ff.brake_en, r_ff.od_en, r_ff.bypass, r_ff.autoscale,
						r_ff.trk_en, r_ff.repeat_req, r_ff.standby_en, r_ff.mode};
					haptic_trig_pkg::SEL_SEQ:    nxt_r.rdata = {24'h000000, r_ff.rpt, r_ff.sel};
					haptic_trig_pkg::SEL_TRIG:   nxt_r.rdata = {8'h00, r_ff.trig};
					haptic_trig_pkg::SEL_PERIOD: nxt_r.rdata = {17'h00000, r_ff.period};
					haptic_trig_pkg::SEL_STATUS: nxt_r.rdata = {19'h00000, r_ff.pass_cnt,
						r_ff.locked, r_ff.seq, r_ff.state, r_ff.fault, r_ff.done};
					default:                     nxt_r.rdata = 32'h00000000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_ff         <= '0;
			r_ff.state   <= haptic_trig_pkg::ST_BOOT;
			r_ff.nominal <= haptic_trig_pkg::PER_DEFAULT;
			r_ff.period  <= haptic_trig_pkg::PER_DEFAULT;
			r_ff.irq_n   <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs, all from flops, some through a gate or state decode
	assign hrdata            = r_ff.rdata;
	assign hreadyout         = 1'b1 | r_ff.wr_pend;
	assign hresp             = 1'b0 & r_ff.wr_pend;
	assign play_start        = r_ff.play_start;
	assign play_seq          = r_ff.seq;
	assign drive_active      = (r_ff.state == haptic_trig_pkg::ST_DRIVE);
	assign standby_active    = (r_ff.state == haptic_trig_pkg::ST_STANDBY);
	assign drive_period      = r_ff.period;
	assign gain_autoscale_on = r_ff.autoscale & r_ff.locked;
	assign overdrive_on      = r_ff.od_en & ~r_ff.wide_en;
	assign brake_on          = r_ff.brake_en & ~r_ff.wide_en;
	assign interrupt_out_n   = r_ff.irq_n;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence reg_start_s;
		r_ff.wr_pend && r_ff.wr_sel == haptic_trig_pkg::SEL_SEQ && hwdata[haptic_trig_pkg::SEQ_TRIG]
		&& r_ff.mode == haptic_trig_pkg::MODE_REG_TRIG && can_start;
	endsequence

	chk_reg_trig_start: assert property (reg_start_s |=> drive_active && play_start
		&& play_seq == r_ff.sel)
		else $error("register trigger did not start playback");
	chk_mode3_no_pin: assert property ((r_ff.mode == haptic_trig_pkg::MODE_REG_TRIG)
		|-> ev == 3'b000)
		else $error("pin event seen outside edge mode");
	chk_seq_end_irq: assert property ((seq_end && !r_ff.done_mask && !(r_ff.by_pin && any_ev))
		|=> !interrupt_out_n)
		else $error("interrupt not raised on completion");
	chk_repeat_nogap: assert property ((seq_end && r_ff.repeat_req && !(r_ff.by_pin && any_ev))
		|=> drive_active && play_start && r_ff.pass_cnt == 4'h0)
		else $error("repeat request left a gap");
	chk_pass_limit: assert property (drive_active |-> r_ff.pass_cnt <= r_ff.rpt)
		else $error("pass count exceeded repeat count");
	chk_pin_stop: assert property ((drive_active && r_ff.by_pin && any_ev) |=> !drive_active)
		else $error("retrigger did not stop playback");
	chk_end_state: assert property ((seq_end && !r_ff.repeat_req && !any_ev)
		|=> (standby_active == $past(r_ff.standby_en)) && !drive_active)
		else $error("wrong state after playback");
	chk_autoscale_lock: assert property (gain_autoscale_on |-> r_ff.locked)
		else $error("autoscale before lock");
	chk_range_fault: assert property ((drive_active && r_ff.trk_en && !r_ff.wide_en && !r_ff.bypass
		&& bemf.valid && !in_range) |=> r_ff.fault && !drive_active)
		else $error("range fault missed");
	chk_boot_len: assert property ($rose(r_ff.state == haptic_trig_pkg::ST_IDLE)
		&& $past(r_ff.state) == haptic_trig_pkg::ST_BOOT
		|-> $past(r_ff.boot_cnt) == haptic_trig_pkg::BOOT_W'(BOOT_CYCLES - 1))
		else $error("boot ended early");

endmodule
`default_nettype wire

/* design/haptic_trig_pkg.sv */
/*
 * Shared constants and types for the haptic sequence trigger control block:
 * register offsets, field positions, reset values, timing and state codes.
 * Assumes a 10 MHz bus clock and 32-bit AHB-Lite register access.
 */
package haptic_trig_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;               // Bus clock period
	localparam int BOOT_TIME_NS  = 1500000;           // Boot time after power-up
	localparam int BOOT_CYCLES   = BOOT_TIME_NS / CLK_PERIOD_NS;
	localparam int BOOT_W        = 16;                // Boot counter width

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;        // Mode and enables
	localparam logic [7:0] OFS_SEQ    = 8'h04;        // Sequence select and trigger
	localparam logic [7:0] OFS_TRIG   = 8'h08;        // Trigger input setup
	localparam logic [7:0] OFS_PERIOD = 8'h0C;        // Drive period high/low
	localparam logic [7:0] OFS_STATUS = 8'h10;        // Events and state

	// Register select codes
	localparam logic [2:0] SEL_NONE   = 3'h0;
	localparam logic [2:0] SEL_CTRL   = 3'h1;
	localparam logic [2:0] SEL_SEQ    = 3'h2;
	localparam logic [2:0] SEL_TRIG   = 3'h3;
	localparam logic [2:0] SEL_PERIOD = 3'h4;
	localparam logic [2:0] SEL_STATUS = 3'h5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;                 // Playback mode, 3 bits
	localparam int CTRL_STBY     = 3;
	localparam int CTRL_RPTREQ   = 4;
	localparam int CTRL_TRK      = 5;
	localparam int CTRL_AUTO     = 6;
	localparam int CTRL_BYPASS   = 7;
	localparam int CTRL_OD       = 8;
	localparam int CTRL_BRAKE    = 9;
	localparam int CTRL_WIDE     = 10;
	localparam int CTRL_DMASK    = 11;
	localparam int SEQ_SEL_LSB   = 0;                 // Sequence select, 4 bits
	localparam int SEQ_RPT_LSB   = 4;                 // Repeat count, 4 bits
	localparam int SEQ_TRIG      = 8;                 // Write-one trigger
	localparam int TRIG_STRIDE   = 8;                 // Bits per trigger input
	localparam int ST_DONE       = 0;
	localparam int ST_FAULT      = 1;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_REG_TRIG  = 3'h3;     // register_triggered_playback
	localparam logic [2:0] MODE_EDGE_TRIG = 3'h4;     // edge_triggered_playback
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	// Period limits in 1333.32 ns units: 300 Hz and 50 Hz
	localparam logic [14:0] PER_MIN     = 15'h09C4;   // 2500
	localparam logic [14:0] PER_MAX     = 15'h3A98;   // 15000
	localparam logic [14:0] PER_DEFAULT = 15'h1D4C;   // 7500, about 100 Hz

	typedef enum logic [1:0] {
		ST_BOOT    = 2'b00,
		ST_IDLE    = 2'b01,
		ST_STANDBY = 2'b10,
		ST_DRIVE   = 2'b11
	} pstate_t;

	// Trigger input setup, one per input
	typedef struct packed {
		logic [3:0] slot;      // trigger_sequence_slot
		logic       scheme;    // trigger_sequence_scheme
		logic [1:0] edge_sel;  // trigger_edge_select
	} trig_cfg_t;

	// Measured resonance from the sensing front end
	typedef struct packed {
		logic        valid;
		logic [14:0] period;
	} bemf_t;

endpackage
